// [verilog/psr_i2c_slave.sv]
// Purpose: two-wire slave readout of bridge and temperature results
// Assumes: SCL and SDA pins arrive asynchronously; result inputs are on core_clk_i
// Notes:   open-drain pins are split into level, drive value and enable
`timescale 1ns/10ps
`default_nettype none
`include "psr_regs.svh"
module psr_i2c_slave #(
   parameter logic [6:0] SLAVE_ADDR = `PSR_ADDR_DEFAULT
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        scl_i,
   output var  logic        scl_o,
   output var  logic        scl_oe_o,
   input  wire logic        sda_i,
   output var  logic        sda_o,
   output var  logic        sda_oe_o,
   input  wire logic        data_valid_i,
   input  wire logic [13:0] bridge_data_i,
   input  wire logic [10:0] temp_data_i,
   output var  logic        meas_start_o,
   output var  logic        drdy_o,
   output var  logic        busy_o
);
   import psr_pkg::*;

   psr_line_if line ();

   psr_pin_sync u_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .line       (line)
   );

   psr_state_t  state_q, state_d;
   logic [7:0]  shift_q, shift_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [1:0]  idx_q, idx_d;
   logic        oe_q, oe_d;
   logic        mr_q, mr_d;
   logic        meas_q, meas_d;
   logic        busy_q, busy_d;
   logic        drdy_q, drdy_d;
   logic        stale_q, stale_d;
   logic [13:0] bridge_q, bridge_d;
   logic [10:0] temp_q, temp_d;
   psr_frame_t  frame_q, frame_d;
   logic [7:0]  next_byte;
   logic        hdr_ours;

   // byte picked by index; past the fourth the last one repeats
   always_comb begin
      case (idx_q)
         2'h0:    next_byte = {frame_q.status, frame_q.bridge[13:8]};
         2'h1:    next_byte = frame_q.bridge[7:0];
         2'h2:    next_byte = frame_q.temp[10:3];
         default: next_byte = {frame_q.temp[2:0], `PSR_PAD_BITS};
      endcase
   end

   assign hdr_ours = (shift_q[7:1] == SLAVE_ADDR) && (shift_q[0] == `PSR_DIR_READ);

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d   = cnt_q;
      idx_d   = idx_q;
      oe_d    = oe_q;
      mr_d    = mr_q;
      frame_d = frame_q;
      meas_d  = 1'b0;
      busy_d  = busy_q;
      if (line.start) begin
         // repeated start is taken from any state
         state_d = PSR_ADDR;
         busy_d  = 1'b1;
         cnt_d   = 4'h0;
         idx_d   = 2'h0;
         oe_d    = 1'b0;
         mr_d    = 1'b0;
      end else if (line.stop) begin
         state_d = PSR_IDLE;
         busy_d  = 1'b0;
         oe_d    = 1'b0;
         meas_d  = mr_q;
         mr_d    = 1'b0;
      end else begin
         case (state_q)
            PSR_IDLE: begin
               oe_d = 1'b0;
            end
            PSR_ADDR: begin
               if (line.scl_rise && cnt_q < `PSR_HDR_BITS) begin
                  shift_d = {shift_q[6:0], line.sda};
                  cnt_d   = cnt_q + 4'h1;
               end else if (line.scl_fall && cnt_q == `PSR_HDR_BITS) begin
                  if (hdr_ours) begin
                     state_d = PSR_HACK;
                     oe_d    = 1'b1;
                     frame_d = '{status: stale_q ? `PSR_STAT_STALE : `PSR_STAT_FRESH,
                                 bridge: bridge_q, temp: temp_q};
                  end else begin
                     state_d = PSR_IGNORE;
                  end
               end
            end
            PSR_HACK: begin
               if (line.scl_rise) begin
                  mr_d = 1'b1;
               end else if (line.scl_fall) begin
                  // direction turns round after a read header
                  state_d = PSR_TX;
                  idx_d   = 2'h0;
                  cnt_d   = 4'h0;
                  shift_d = next_byte;
                  oe_d    = ~next_byte[7];
               end
            end
            PSR_TX: begin
               // a rise here may still end in a stop; only a finished bit cancels the request
               if (line.scl_fall) begin
                  mr_d = 1'b0;
                  if (cnt_q[2:0] == `PSR_BIT_LAST) begin
                     state_d = PSR_TACK;
                     oe_d    = 1'b0;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     cnt_d   = cnt_q + 4'h1;
                     oe_d    = ~shift_q[6];
                  end
               end
            end
            PSR_TACK: begin
               if (line.scl_rise) begin
                  if (line.sda) begin
                     state_d = PSR_IDLE;
                  end else begin
                     state_d = PSR_TWAIT;
                     if (idx_q != `PSR_BYTE_LAST) begin
                        idx_d = idx_q + 2'h1;
                     end
                  end
               end
            end
            PSR_TWAIT: begin
               if (line.scl_fall) begin
                  state_d = PSR_TX;
                  cnt_d   = 4'h0;
                  shift_d = next_byte;
                  oe_d    = ~next_byte[7];
               end
            end
            PSR_IGNORE: begin
               oe_d = 1'b0;
            end
            default: begin
               state_d = PSR_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   // result holding and flags; a new result beats a same-cycle fetch
   always_comb begin
      bridge_d = bridge_q;
      temp_d   = temp_q;
      stale_d  = stale_q;
      drdy_d   = drdy_q;
      if (line.start) begin
         drdy_d = 1'b0;
      end
      if (state_q == PSR_TACK && line.scl_rise) begin
         stale_d = 1'b1;
      end
      if (data_valid_i) begin
         bridge_d = bridge_data_i;
         temp_d   = temp_data_i;
         stale_d  = 1'b0;
         drdy_d   = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q  <= PSR_IDLE;
         shift_q  <= 8'h00;
         cnt_q    <= 4'h0;
         idx_q    <= 2'h0;
         oe_q     <= 1'b0;
         mr_q     <= 1'b0;
         meas_q   <= 1'b0;
         busy_q   <= 1'b0;
         drdy_q   <= 1'b0;
         stale_q  <= 1'b1;
         bridge_q <= 14'h0000;
         temp_q   <= 11'h000;
         frame_q  <= '0;
      end else begin
         state_q  <= state_d;
         shift_q  <= shift_d;
         cnt_q    <= cnt_d;
         idx_q    <= idx_d;
         oe_q     <= oe_d;
         mr_q     <= mr_d;
         meas_q   <= meas_d;
         busy_q   <= busy_d;
         drdy_q   <= drdy_d;
         stale_q  <= stale_d;
         bridge_q <= bridge_d;
         temp_q   <= temp_d;
         frame_q  <= frame_d;
      end
   end

   // pins only ever pull low; the pull-up supplies high
   logic pin_low_q;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_low_q <= 1'b0;
      end else begin
         pin_low_q <= 1'b0;
      end
   end

   assign sda_o        = pin_low_q;
   assign scl_o        = pin_low_q;
   assign sda_oe_o     = oe_q;
   assign scl_oe_o     = pin_low_q;
   assign meas_start_o = meas_q;
   assign drdy_o       = drdy_q;
   assign busy_o       = busy_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence hdr_done_s;
      state_q == PSR_ADDR && line.scl_fall && cnt_q == `PSR_HDR_BITS && !line.start && !line.stop;
   endsequence

   sequence nack_seen_s;
      state_q == PSR_TACK && line.scl_rise && line.sda && !line.start && !line.stop;
   endsequence

   pin_low_only_a: assert property (sda_o == 1'b0 && scl_oe_o == 1'b0)
      else $error("open-drain pin driven high or scl driven");
   own_hdr_ack_a: assert property (hdr_done_s and hdr_ours |=> state_q == PSR_HACK && sda_oe_o)
      else $error("own read header not acknowledged");
   write_hdr_skip_a: assert property (hdr_done_s and shift_q[0] != `PSR_DIR_READ |=> state_q == PSR_IGNORE)
      else $error("write header was not ignored");
   foreign_quiet_a: assert property (state_q == PSR_IGNORE |-> !sda_oe_o)
      else $error("sda pulled during foreign transaction");
   start_busy_a: assert property (line.start |=> busy_o && state_q == PSR_ADDR)
      else $error("start did not mark bus busy");
   stop_free_a: assert property (line.stop && !line.start |=> !busy_o && !sda_oe_o)
      else $error("stop did not free the bus");
   nack_idle_a: assert property (nack_seen_s |=> state_q == PSR_IDLE ##1 !sda_oe_o)
      else $error("device kept sending after nack");
   meas_req_a: assert property (line.stop && mr_q |=> meas_start_o ##1 !meas_start_o)
      else $error("measurement request not started once");
   drdy_fall_a: assert property (line.start && !data_valid_i |=> !drdy_o)
      else $error("data ready not lowered on transaction");
   drdy_rise_a: assert property (data_valid_i |=> drdy_o && bridge_q == $past(bridge_data_i)
                                 && temp_q == $past(temp_data_i))
      else $error("data ready not raised on new data");
   first_msb_a: assert property (state_q == PSR_HACK && line.scl_fall && !line.start && !line.stop
                                 |=> sda_oe_o == !frame_q.status[1])
      else $error("first byte msb not presented");
   stale_stat_a: assert property (hdr_done_s and hdr_ours and stale_q and !data_valid_i
                                  |=> frame_q.status == `PSR_STAT_STALE)
      else $error("stale status not reported");
   ack_release_a: assert property (state_q == PSR_TX && line.scl_fall && cnt_q[2:0] == `PSR_BIT_LAST
                                   && !line.start && !line.stop |=> !sda_oe_o [*2])
      else $error("sda not released for master acknowledge");
endmodule
`default_nettype wire

// [include/psr_regs.svh]
// Purpose: constants for the pressure sensor two-wire readout port
// Assumes: included by bare name after the package
// Notes:   no software registers; these are bus and frame constants
//
// What this block does
// - SDA and SCL are only pulled low, never driven high; pull-ups make high.
// - answer one 7-bit address, fixed at build to 0x28, 0x36 or 0x46.
// - header is seven address bits then direction bit, 0 write, 1 read.
// - data-ready rises on fresh data, falls on the next bus transaction.
// - SDA falling while SCL high is start; bus is busy from then.
// - SDA rising while SCL high is stop; bus is free from then.
// - receiver pulls SDA low in the ninth clock to acknowledge a byte.
// - SDA left high in the ninth clock is a not-acknowledge.
// - master not-acknowledging a sent byte ends transmission, device goes idle.
// - all transfers are eight-bit bytes, MSB first, each with acknowledge.
// - after a read header the device drives SDA for the following bytes.
// - device acknowledges a read header carrying its own address.
// - acknowledged read header followed straight by stop starts one measurement.
// - first byte is status plus bridge 13..8, second byte bridge 7..0.
// - third byte carries temperature bits 10..3.
// - fourth byte carries temperature 2..0 on top, five undefined low bits.
// - device keeps sending bytes until master not-acknowledges and stops.
// - status bits read 00 for a fresh packet, 10 once already fetched.
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH
`define PSR_ADDR_DEFAULT 7'h28
`define PSR_DIR_READ     1'b1
`define PSR_STAT_FRESH   2'h0
`define PSR_STAT_STALE   2'h2
`define PSR_BIT_LAST     3'h7
`define PSR_HDR_BITS     4'h8
`define PSR_BYTE_LAST    2'h3
`define PSR_PAD_BITS     5'h00
`endif

// [include/psr_pkg.sv]
// Purpose: types of the pressure sensor readout port
// Assumes: nothing
// Notes:   constants live in psr_regs.svh
package psr_pkg;
   typedef enum logic [2:0] {
      PSR_IDLE   = 3'b000,
      PSR_ADDR   = 3'b001,
      PSR_HACK   = 3'b010,
      PSR_TX     = 3'b011,
      PSR_TACK   = 3'b100,
      PSR_TWAIT  = 3'b101,
      PSR_IGNORE = 3'b110
   } psr_state_t;

   typedef struct packed {
      logic [1:0]  status;
      logic [13:0] bridge;
      logic [10:0] temp;
   } psr_frame_t;
endpackage

// [include/psr_line_if.sv]
// Purpose: synchronised bus line levels and events between sampler and engine
// Assumes: one clock domain, core_clk_i
// Notes:   every event is a single-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface psr_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport src (output scl, sda, scl_rise, scl_fall, start, stop);
   modport dst (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// [verilog/psr_pin_sync.sv]
// Purpose: three-flop sampling of SCL and SDA plus edge and condition detection
// Assumes: SCL far slower than core_clk_i
// Notes:   events come from the second and third stages only
`timescale 1ns/10ps
`default_nettype none
module psr_pin_sync (
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   psr_line_if.src   line
);
   logic [2:0] scl_q, scl_d;
   logic [2:0] sda_q, sda_d;
   logic       rise_d, fall_d, start_d, stop_d;
   logic       rise_q, fall_q, start_q, stop_q;

   always_comb begin
      scl_d   = {scl_q[1:0], scl_i};
      sda_d   = {sda_q[1:0], sda_i};
      rise_d  = scl_q[1] & ~scl_q[2];
      fall_d  = ~scl_q[1] & scl_q[2];
      // data edge while clock stays high marks start or stop
      start_d = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
      stop_d  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q   <= 3'h7;
         sda_q   <= 3'h7;
         rise_q  <= 1'b0;
         fall_q  <= 1'b0;
         start_q <= 1'b0;
         stop_q  <= 1'b0;
      end else begin
         scl_q   <= scl_d;
         sda_q   <= sda_d;
         rise_q  <= rise_d;
         fall_q  <= fall_d;
         start_q <= start_d;
         stop_q  <= stop_d;
      end
   end

   assign line.scl      = scl_q[2];
   assign line.sda      = sda_q[2];
   assign line.scl_rise = rise_q;
   assign line.scl_fall = fall_q;
   assign line.start    = start_q;
   assign line.stop     = stop_q;
endmodule
`default_nettype wire

// [tb/psr_bus_master.sv]
// Purpose: behavioural two-wire bus master facing the sensor port
// Assumes: core_clk_i at 50 MHz, one bus bit every 8 clocks (160 ns)
// Notes:   open-drain only; a released line reads high through the pull-up
`timescale 1ns/10ps
`default_nettype none
module psr_bus_master (
   input  wire logic core_clk_i,
   input  wire logic sda_i,
   output var  logic scl_oe_o,
   output var  logic sda_oe_o
);
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // scl low 5 clocks, high 3: the slave answers 4 clocks after the fall
   task automatic clk_bit(input logic v, output logic r);
      tick(1);
      sda_oe_o <= ~v;
      tick(4);
      scl_oe_o <= 1'b0;
      tick(3);
      r = sda_i;
      scl_oe_o <= 1'b1;
   endtask
   task automatic start_cond;
      tick(1);
      sda_oe_o <= 1'b0;
      tick(2);
      scl_oe_o <= 1'b0;
      tick(4);
      sda_oe_o <= 1'b1;
      tick(4);
      scl_oe_o <= 1'b1;
   endtask
   task automatic stop_cond;
      tick(1);
      sda_oe_o <= 1'b1;
      tick(4);
      scl_oe_o <= 1'b0;
      tick(4);
      sda_oe_o <= 1'b0;
      tick(6);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask
   // master picks the length by when it answers with a not-acknowledge
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
      clk_bit(last, r);
   endtask
endmodule
`default_nettype wire

// [tb/psr_i2c_slave_tb_top.sv]
// Purpose: self-checking bench for the sensor two-wire readout port
// Assumes: bus master model in psr_bus_master
// Notes:   random results with fixed seed; wire levels resolved here
`timescale 1ns/10ps
`default_nettype none
module psr_i2c_slave_tb_top;
   localparam logic [6:0] OWN_ADDR = 7'h36;
   logic        core_clk_i;
   logic        rst_b_i;
   logic        data_valid_i;
   logic [13:0] bridge_data_i;
   logic [10:0] temp_data_i;
   logic        scl_o, scl_oe_o, sda_o, sda_oe_o;
   logic        meas_start_o, drdy_o, busy_o, m_scl_oe, m_sda_oe;
   int          n_fail, cmp_count, n_meas;
   integer      seed;
   logic [31:0] v;
   wire logic   scl_w = !(m_scl_oe || (scl_oe_o && !scl_o));
   wire logic   sda_w = !(m_sda_oe || (sda_oe_o && !sda_o));

   psr_i2c_slave #(.SLAVE_ADDR(OWN_ADDR)) psr_i2c_slave_inst (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .data_valid_i(data_valid_i), .bridge_data_i(bridge_data_i), .temp_data_i(temp_data_i),
      .meas_start_o(meas_start_o), .drdy_o(drdy_o), .busy_o(busy_o));
   psr_bus_master psr_bus_master_inst (
      .core_clk_i(core_clk_i), .sda_i(sda_w), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) if (meas_start_o === 1'b1) n_meas <= n_meas + 1;

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [7:0] exp_byte(input int k, input logic [1:0] st,
                                          input logic [13:0] br, input logic [10:0] tp);
      logic [31:0] f;
      f = {st, br, tp, 5'h00};
      return f[31 - 8 * (k > 3 ? 3 : k) -: 8];
   endfunction
   task automatic post(input logic [13:0] br, input logic [10:0] tp);
      @(posedge core_clk_i);
      data_valid_i  <= 1'b1;
      bridge_data_i <= br;
      temp_data_i   <= tp;
      @(posedge core_clk_i);
      data_valid_i  <= 1'b0;
      bridge_data_i <= ~br;
      temp_data_i   <= ~tp;
      repeat (2) @(posedge core_clk_i);
      check({7'h00, drdy_o}, 8'h01, "ready after result");
   endtask
   task automatic fetch(input int n, input logic [1:0] st, input logic [13:0] br, input logic [10:0] tp);
      logic       ack;
      logic [7:0] b;
      logic [7:0] m;
      psr_bus_master_inst.start_cond();
      @(negedge core_clk_i);
      check({7'h00, busy_o}, 8'h01, "busy after start");
      check({7'h00, drdy_o}, 8'h00, "ready after start");
      psr_bus_master_inst.send_byte({OWN_ADDR, 1'b1}, ack);
      check({7'h00, ack}, 8'h01, "header ack");
      for (int k = 0; k < n; k++) begin
         psr_bus_master_inst.get_byte(k == n - 1, b);
         m = (k >= 3) ? 8'hE0 : 8'hFF;
         check(b & m, exp_byte(k, st, br, tp) & m, "data byte");
      end
      psr_bus_master_inst.get_byte(1'b1, b);
      check(b, 8'hFF, "quiet after nack");
      psr_bus_master_inst.stop_cond();
      check({7'h00, busy_o}, 8'h00, "busy after stop");
   endtask
   task automatic header_only(input logic [7:0] hdr, input logic exp_ack, input int exp_meas);
      logic       ack;
      logic [7:0] b;
      int         m0;
      m0 = n_meas;
      psr_bus_master_inst.start_cond();
      psr_bus_master_inst.send_byte(hdr, ack);
      check({7'h00, ack}, {7'h00, exp_ack}, "header answer");
      if (!exp_ack) begin
         psr_bus_master_inst.get_byte(1'b1, b);
         check(b, 8'hFF, "released line");
      end
      psr_bus_master_inst.stop_cond();
      check(8'(n_meas - m0), 8'(exp_meas), "measure pulses");
      $display("header %h done", hdr);
   endtask

   initial begin
      logic [13:0] br;
      logic [10:0] tp;
      seed          = 32'h898275FD;
      n_fail        = 0;
      cmp_count     = 0;
      n_meas        = 0;
      rst_b_i       = 1'b0;
      data_valid_i  = 1'b0;
      bridge_data_i = 14'h0000;
      temp_data_i   = 11'h000;
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      for (int t = 0; t < 12; t++) begin
         v  = $random(seed);
         br = (t == 0) ? 14'h3FFF : v[13:0];
         tp = (t == 1) ? 11'h000 : v[26:16];
         post(br, tp);
         fetch(2 + t % 4, 2'h0, br, tp);
         fetch(2 + t % 3, 2'h2, br, tp);
         $display("fetch test %0d done", t);
      end
      header_only({OWN_ADDR, 1'b1}, 1'b1, 1);
      header_only({OWN_ADDR, 1'b0}, 1'b0, 0);
      header_only({7'h28, 1'b1}, 1'b0, 0);
      header_only({7'h46, 1'b1}, 1'b0, 0);
      header_only({OWN_ADDR ^ 7'h01, 1'b1}, 1'b0, 0);
      header_only({OWN_ADDR, 1'b1}, 1'b1, 1);
      wrap_up();
   end
   initial begin
      #1000000;
      n_fail++;
      $display("Error at %0t: run did not finish", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
